// >>> testbench/stp_props.sv
// Purpose: concurrent checks on the port state logic
// Assumes: sees only the top module ports
// Notes: bound into every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module stp_props
  import stp_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // watched inputs
  input wire logic CFG_LOAD_I,
  input wire logic [3:0] HELLO_TIME_I,
  input wire logic [5:0] MAX_AGE_I,
  input wire logic [NPORT-1:0] PORT_EN_I,
  input wire logic [NPORT-1:0] PORT_BLOCK_I,
  input wire logic RX_BPDU_I,
  input wire logic [ID_W-1:0] RX_ROOT_ID_I,
  input wire logic IN_VALID_I,
  input wire logic [1:0] IN_PORT_I,
  input wire logic [1:0] IN_KIND_I,
  // watched outputs
  input wire logic IN_READY_O,
  input wire logic [NPORT-1:0] FWD_EN_O,
  input wire logic [NPORT-1:0] LEARN_EN_O,
  input wire logic [NPORT-1:0] CPU_RX_EN_O,
  input wire logic [NPORT-1:0] CPU_TX_EN_O,
  input wire logic [NPORT*3-1:0] PORT_STATE_O,
  input wire logic LEARN_O,
  input wire logic [1:0] LEARN_PORT_O,
  input wire logic IS_ROOT_O,
  input wire logic [ID_W-1:0] ROOT_ID_O,
  input wire logic RANGE_ERR_O,
  input wire logic CFG_ERR_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // gates {forward, learn, cpu rx, cpu tx} owed in each state
  function automatic logic [3:0] gates(input logic [2:0] s);
    case (s)
      3'h0: return 4'h2;
      3'h1: return 4'h3;
      3'h2: return 4'h7;
      3'h3: return 4'hf;
      default: return 4'h0;
    endcase
  endfunction
  // the only state steps a port may take
  function automatic logic legal(input logic [2:0] p, input logic [2:0] n);
    return n == 3'h4 || n == p + 3'h1 && p < 3'h3
      || n == 3'h0 && (p == 3'h4 || p == 3'h1);
  endfunction
  hello_range_a: assert property (
    CFG_LOAD_I && (HELLO_TIME_I > 4'ha || HELLO_TIME_I == 4'h0)
    |=> RANGE_ERR_O) else $error("bad hello time accepted");
  age_range_a: assert property (
    CFG_LOAD_I && (MAX_AGE_I < 6'h06 || MAX_AGE_I > 6'h28)
    |=> RANGE_ERR_O) else $error("bad maximum age accepted");
  cfg_err_a: assert property (
    CFG_LOAD_I && HELLO_TIME_I > MAX_AGE_I |=> RANGE_ERR_O || CFG_ERR_O)
    else $error("hello above age not flagged");
  root_lose_a: assert property (
    RX_BPDU_I && RX_ROOT_ID_I < ROOT_ID_O
    |=> !IS_ROOT_O && ROOT_ID_O == $past(RX_ROOT_ID_I))
    else $error("better root not taken");
  for (genvar p = 0; p < NPORT; p++) begin : g_port
    port_gate_a: assert property (
      {FWD_EN_O[p], LEARN_EN_O[p], CPU_RX_EN_O[p], CPU_TX_EN_O[p]}
      == gates(PORT_STATE_O[p*3+:3])) else $error("gates wrong for state");
  end
  state_step_a: assert property (
    $changed(PORT_STATE_O[2:0])
    |-> legal($past(PORT_STATE_O[2:0]), PORT_STATE_O[2:0]))
    else $error("illegal state step");
  listen_back_a: assert property (
    PORT_STATE_O[11:9] == 3'h1 && PORT_BLOCK_I[3] && PORT_EN_I[3]
    |=> PORT_STATE_O[11:9] == 3'h0) else $error("listening kept");
  learn_event_a: assert property (
    IN_VALID_I && IN_READY_O && IN_KIND_I == 2'h0
    && PORT_STATE_O[IN_PORT_I*3+:3] inside {3'h2, 3'h3}
    |=> LEARN_O && LEARN_PORT_O == $past(IN_PORT_I))
    else $error("address not learned");
  // main scenarios reached
  cover property (LEARN_O);
  cover property (!IN_READY_O);
  cover property (!IS_ROOT_O);
endmodule
bind stp_port_ctl stp_props u_props (.CLK_SYS_I, .RST_I, .CFG_LOAD_I,
  .HELLO_TIME_I, .MAX_AGE_I, .PORT_EN_I, .PORT_BLOCK_I, .RX_BPDU_I,
  .RX_ROOT_ID_I, .IN_VALID_I, .IN_PORT_I, .IN_KIND_I, .IN_READY_O,
  .FWD_EN_O, .LEARN_EN_O, .CPU_RX_EN_O, .CPU_TX_EN_O, .PORT_STATE_O,
  .LEARN_O, .LEARN_PORT_O, .IS_ROOT_O, .ROOT_ID_O, .RANGE_ERR_O,
  .CFG_ERR_O);
`default_nettype wire

// >>> testbench/stp_sink_model.sv
// Purpose: fabric and cpu side taking the outgoing words
// Assumes: one clock, accepts on valid and ready
// Notes: mode 0 always ready, 1 random stalls, 2 stalled
`timescale 1ns/1ps
`default_nettype none
module stp_sink_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stall mode
  input wire logic [1:0] mode_i,
  // acceptance towards the block
  output var logic ready_o
);
  // ready moves just after the edge, as a real sink does
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'h0;
    end else begin
      ready_o <= mode_i == 2'h0 || mode_i == 2'h1 && $urandom_range(2) == 0;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Purpose: self-checking bench for the port state logic
// Assumes: one second shortened to four clocks
// Notes: a queue holds the words expected at the output
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
  import stp_pkg::*;
  localparam int SEC = 4;
  // stimulus
  logic CLK_SYS_I = 1'h0;
  logic RST_I = 1'h1;
  logic CFG_LOAD_I = 1'h0;
  logic RX_BPDU_I = 1'h0;
  logic IN_VALID_I = 1'h0;
  logic [15:0] BRIDGE_PRIO_I = PRIO_RST;
  logic [3:0] HELLO_TIME_I = HELLO_RST;
  logic [5:0] MAX_AGE_I = AGE_RST;
  logic [4:0] FWD_DELAY_I = FWD_RST;
  logic [31:0] PORT_PRIO_I = {4{PPRIO_RST}};
  logic [63:0] PORT_COST_I = {4{COST_RST}};
  logic [47:0] STATION_ADDR_I = 48'h0000_0000_0a00;
  logic [3:0] PORT_EN_I = 4'hb;
  logic [3:0] PORT_BLOCK_I = 4'h2;
  logic [63:0] RX_ROOT_ID_I = 64'h0;
  logic [1:0] IN_PORT_I = 2'h0;
  logic [1:0] IN_KIND_I = 2'h0;
  logic [31:0] IN_DATA_I = 32'h0;
  logic [1:0] mode = 2'h0;
  // observed
  logic OUT_READY_I, IN_READY_O, OUT_VALID_O, OUT_TO_CPU_O, LEARN_O;
  logic IS_ROOT_O, HELLO_TX_O, RANGE_ERR_O, CFG_ERR_O;
  logic [1:0] OUT_PORT_O, OUT_KIND_O, LEARN_PORT_O, PREF_PORT_O;
  logic [31:0] OUT_DATA_O;
  logic [3:0] FWD_EN_O, LEARN_EN_O, CPU_RX_EN_O, CPU_TX_EN_O, g0;
  logic [11:0] PORT_STATE_O;
  logic [63:0] ROOT_ID_O;
  int fails = 0, checked = 0, cyc = 0, seed;
  stp_word_s q[$];
  stp_word_s got, want;
  stp_port_ctl #(.SEC_CYCLES(SEC)) uut (.CLK_SYS_I, .RST_I, .CFG_LOAD_I,
    .BRIDGE_PRIO_I, .HELLO_TIME_I, .MAX_AGE_I, .FWD_DELAY_I, .PORT_PRIO_I,
    .PORT_COST_I, .STATION_ADDR_I, .PORT_EN_I, .PORT_BLOCK_I, .RX_BPDU_I,
    .RX_ROOT_ID_I, .IN_VALID_I, .IN_PORT_I, .IN_KIND_I, .IN_DATA_I,
    .IN_READY_O, .OUT_VALID_O, .OUT_TO_CPU_O, .OUT_PORT_O, .OUT_KIND_O,
    .OUT_DATA_O, .OUT_READY_I, .FWD_EN_O, .LEARN_EN_O, .CPU_RX_EN_O,
    .CPU_TX_EN_O, .PORT_STATE_O, .LEARN_O, .LEARN_PORT_O, .IS_ROOT_O,
    .ROOT_ID_O, .HELLO_TX_O, .PREF_PORT_O, .RANGE_ERR_O, .CFG_ERR_O);
  stp_sink_model u_sink (.clk_i(CLK_SYS_I), .rst_i(RST_I), .mode_i(mode),
    .ready_o(OUT_READY_I));
  // port 0 gates as {forward, learn, cpu rx, cpu tx}
  assign g0 = {FWD_EN_O[0], LEARN_EN_O[0], CPU_RX_EN_O[0], CPU_TX_EN_O[0]};
  // clock
  always #20 CLK_SYS_I = ~CLK_SYS_I;
  // verdict and end of run
  task automatic test_done();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // cut a hang short
  always @(posedge CLK_SYS_I) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      test_done();
    end
  end
  // compare each accepted word with the oldest expectation
  always @(posedge CLK_SYS_I) begin
    if (!RST_I && OUT_VALID_O && OUT_READY_I) begin
      got = {OUT_TO_CPU_O, OUT_PORT_O, OUT_KIND_O, OUT_DATA_O};
      want = q.size() > 0 ? q.pop_front() : ~got;
      `CHK(got, want)
    end
  end
  // let n rising edges pass; outputs read here still hold the values set at the edge before the last
  task automatic step(input int n);
    repeat (n) @(posedge CLK_SYS_I);
  endtask
  // one configuration load; returns once the answer stands
  task automatic load(input logic [3:0] h, input logic [5:0] a,
      input logic [4:0] f);
    CFG_LOAD_I <= 1'h1;
    HELLO_TIME_I <= h;
    MAX_AGE_I <= a;
    FWD_DELAY_I <= f;
    step(1);
    CFG_LOAD_I <= 1'h0;
    step(1);
  endtask
  // offer a word; note it when the gate of its port lets it through
  task automatic send(input logic [1:0] k, input logic [1:0] p,
      input logic [31:0] d);
    logic [2:0] s;
    IN_VALID_I <= 1'h1;
    IN_KIND_I <= k;
    IN_PORT_I <= p;
    IN_DATA_I <= d;
    do step(1); while (IN_READY_O !== 1'h1);
    s = PORT_STATE_O[p*3+:3];
    if (k == 2'h2 || k == 2'h1 && s != 3'h4 || k == 2'h0 && s == 3'h3)
      q.push_back({k != 2'h0, p, k, d});
  endtask
  // wait for port 0 to reach a state, bounded so a stuck port fails
  task automatic wait_st(input logic [2:0] s);
    int n = 0;
    while (PORT_STATE_O[2:0] !== s && n < 200) begin
      step(1);
      n++;
    end
    `CHK(PORT_STATE_O[2:0], s)
  endtask
  // cycles between two hello pulses
  task automatic hello_gap(input int w);
    int n = 0;
    while (HELLO_TX_O !== 1'h1 && n < 400) begin
      step(1);
      n++;
    end
    n = 0;
    do begin
      step(1);
      n++;
    end while (HELLO_TX_O !== 1'h1 && n < 400);
    `CHK(n, w)
  endtask
  // scenarios: reset, loads, port walk, stream, root loss and bid
  initial begin
    int n;
    seed = $urandom(48);
    step(6);
    RST_I <= 1'h0;
    step(2);
    `CHK(PORT_STATE_O, 12'h100)
    `CHK({IS_ROOT_O, CPU_RX_EN_O, RANGE_ERR_O}, 6'h36)
    `CHK(ROOT_ID_O, {PRIO_RST, STATION_ADDR_I})
    load(4'hc, AGE_RST, FWD_RST);
    `CHK({RANGE_ERR_O, CFG_ERR_O}, 2'h2)
    load(4'ha, 6'h06, FWD_RST);
    `CHK({RANGE_ERR_O, CFG_ERR_O}, 2'h1)
    load(4'h2, 6'h29, FWD_RST);
    `CHK({RANGE_ERR_O, CFG_ERR_O}, 2'h3)
    load(4'h2, AGE_RST, 5'h03);
    `CHK({RANGE_ERR_O, CFG_ERR_O}, 2'h3)
    PORT_COST_I <= 64'h0005_0001_0000_ffff;
    load(4'h1, 6'h06, 5'h04);
    `CHK(RANGE_ERR_O, 1'h1)
    PORT_COST_I <= 64'h0005_0001_0005_ffff;
    PORT_PRIO_I <= 32'h0080ff80;
    BRIDGE_PRIO_I <= 16'h0000;
    load(4'h1, 6'h06, 5'h04); // limits kept by the loading side
    step(1);
    `CHK({RANGE_ERR_O, CFG_ERR_O, PREF_PORT_O}, 4'h3)
    `CHK(ROOT_ID_O, {16'h0000, STATION_ADDR_I})
    hello_gap(SEC);
    wait_st(3'h1);
    PORT_BLOCK_I <= 4'ha;
    `CHK(g0, 4'h3)
    `CHK(PORT_STATE_O[5:3], 3'h0)
    wait_st(3'h2);
    `CHK(g0, 4'h7)
    send(2'h0, 2'h0, $urandom);
    IN_VALID_I <= 1'h0;
    step(1);
    `CHK({LEARN_O, LEARN_PORT_O}, 3'h4)
    wait_st(3'h3);
    `CHK(g0, 4'hf)
    `CHK(PORT_STATE_O[11:3], 9'h020)
    mode <= 2'h2;
    step(1);
    send(2'h2, 2'h2, $urandom);
    send(2'h1, 2'h1, $urandom);
    IN_VALID_I <= 1'h0;
    step(2);
    `CHK({IN_READY_O, OUT_VALID_O}, 2'h1)
    mode <= 2'h1;
    repeat (40) send(2'($urandom), 2'($urandom), $urandom);
    IN_VALID_I <= 1'h0;
    mode <= 2'h0;
    for (n = 0; n < 200 && q.size() != 0; n++) step(1);
    step(2);
    `CHK(q.size(), 0)
    RX_BPDU_I <= 1'h1;
    RX_ROOT_ID_I <= 64'h1;
    step(1);
    RX_BPDU_I <= 1'h0;
    step(1);
    `CHK({IS_ROOT_O, ROOT_ID_O}, 65'h1)
    load(4'h2, 6'h06, 5'h04);
    for (n = 0; n < 200 && IS_ROOT_O !== 1'h1; n++) step(1);
    `CHK({IS_ROOT_O, n > 15}, 2'h3)
    step(1);
    hello_gap(2 * SEC);
    PORT_EN_I <= 4'hf;
    step(3);
    `CHK({PORT_STATE_O[8:6], PREF_PORT_O}, 5'h02)
    test_done();
  end
endmodule
`default_nettype wire

// >>> verilog/stp_buf2.sv
// Purpose: two-entry buffer; head entry and flags are flip-flops
// Assumes: push and pop may happen in the same cycle
// Notes: entry 0 is always the head, so outputs need no mux
`timescale 1ns/1ps
`default_nettype none
module stp_buf2
  import stp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // stream
  stp_stream_if.store bus
);
  typedef struct packed {
    stp_word_s [1:0] ent;
    logic [1:0] cnt;
    logic vld;
    logic rdy;
  } stp_buf_s;

  stp_buf_s s_reg;
  stp_buf_s s_next;
  logic push;
  logic pop;
  logic [1:0] wr;

  // handshakes use registered flags only
  assign push = bus.push_valid & s_reg.rdy;
  assign pop = s_reg.vld & bus.pop_ready;

  // shift on pop, write behind the last kept entry
  always_comb begin
    s_next = s_reg;
    wr = s_reg.cnt;
    if (pop) begin
      s_next.ent[0] = s_reg.ent[1];
      wr = s_reg.cnt - 2'h1;
    end
    if (push) begin
      s_next.ent[wr[0]] = bus.push_word;
    end
    s_next.cnt = wr + {1'b0, push};
    s_next.vld = s_next.cnt != 2'h0;
    s_next.rdy = s_next.cnt != 2'h2;
  end

  // state register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus.push_ready = s_reg.rdy;
  assign bus.pop_valid = s_reg.vld;
  assign bus.pop_word = s_reg.ent[0];
endmodule
`default_nettype wire

// >>> verilog/stp_pkg.sv
// Purpose: shared constants and types of the port state logic
// Assumes: 25 MHz system clock, four switch ports
// Notes: ranges and reset values are in seconds or raw units
`default_nettype none
package stp_pkg;
  // geometry
  localparam int NPORT = 4;
  localparam int DATA_W = 32;
  localparam int ID_W = 64;
  // time base
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_SEC = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_SEC;
  // accepted ranges
  localparam logic [3:0] HELLO_MIN = 4'h1;
  localparam logic [3:0] HELLO_MAX = 4'ha;
  localparam logic [5:0] AGE_MIN = 6'h06;
  localparam logic [5:0] AGE_MAX = 6'h28;
  localparam logic [4:0] FWD_MIN = 5'h04;
  localparam logic [4:0] FWD_MAX = 5'h1e;
  localparam logic [15:0] COST_MIN = 16'h0001;
  // reset values
  localparam logic [15:0] PRIO_RST = 16'h8000;
  localparam logic [3:0] HELLO_RST = 4'h2;
  localparam logic [5:0] AGE_RST = 6'h14;
  localparam logic [4:0] FWD_RST = 5'h0f;
  localparam logic [7:0] PPRIO_RST = 8'h80;
  localparam logic [15:0] COST_RST = 16'h0013;
  // port states
  typedef enum logic [2:0] {
    PS_BLOCK, PS_LISTEN, PS_LEARN, PS_FWD, PS_DIS
  } stp_pst_e;
  // kinds of arriving frame
  typedef enum logic [1:0] {
    K_DATA, K_BPDU, K_MGMT, K_RSVD
  } stp_kind_e;
  // one word in the outgoing stream
  typedef struct packed {
    logic to_cpu;
    logic [1:0] port;
    stp_kind_e kind;
    logic [DATA_W-1:0] data;
  } stp_word_s;
endpackage
`default_nettype wire

// >>> verilog/stp_port_ctl.sv
// Purpose: spanning-tree port states, timers and frame gating
// Assumes: cpu computes port roles; one-second base derived here
// Notes: every output comes from a flip-flop
// What this block does
// - bridge priority takes any value 0 to 65535; zero is best.
// - hello time 1 to 10 s; root sends hello at that interval.
// - hello time stored while not root is used once root.
// - flag an error while hello time exceeds maximum age.
// - maximum age takes 6 to 40 s.
// - maximum age expiry without root hello makes us bid as root.
// - lowest bridge identifier wins the root role.
// - forward delay 4 to 30 s sets each dwell in listening.
// - port priority 0 to 255; lower favours root port choice.
// - port cost 1 to 65535; lower favours forwarding choice.
// - after reset enabled ports block and bridge assumes root.
// - alone, blocking moves to listening at forward timer expiry.
// - blocking drops data, no learning, bpdu to cpu, no cpu send.
// - listening drops data, no learning, bpdus both ways.
// - listening returns to blocking when another port is better.
// - listening moves to learning at forward timer expiry.
// - learning drops data, learns addresses, sends cpu bpdus.
// - learning moves to forwarding at next timer expiry.
// - forwarding passes data, learns, bpdus to cpu.
// - disabled drops all but management, learns nothing, bpdus not to cpu.
// - management messages are received in every state.
// - only the documented state steps; disabled returns to blocking.
// - bridge id is 16-bit priority joined to 48-bit address.
`timescale 1ns/1ps
`default_nettype none
module stp_port_ctl
  import stp_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = TICK_CYCLES
)
(
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // bridge configuration, taken on CFG_LOAD_I; STATION_ADDR_I is used live
  input wire logic CFG_LOAD_I,
  input wire logic [15:0] BRIDGE_PRIO_I,
  input wire logic [3:0] HELLO_TIME_I,
  input wire logic [5:0] MAX_AGE_I,
  input wire logic [4:0] FWD_DELAY_I,
  input wire logic [NPORT*8-1:0] PORT_PRIO_I,
  input wire logic [NPORT*16-1:0] PORT_COST_I,
  input wire logic [47:0] STATION_ADDR_I,
  // per-port control from the cpu
  input wire logic [NPORT-1:0] PORT_EN_I,
  input wire logic [NPORT-1:0] PORT_BLOCK_I,
  // received protocol unit summary
  input wire logic RX_BPDU_I,
  input wire logic [ID_W-1:0] RX_ROOT_ID_I,
  // frames arriving from the segments
  input wire logic IN_VALID_I,
  input wire logic [1:0] IN_PORT_I,
  input wire logic [1:0] IN_KIND_I,
  input wire logic [DATA_W-1:0] IN_DATA_I,
  output logic IN_READY_O,
  // frames passed to fabric or cpu
  output logic OUT_VALID_O,
  output logic OUT_TO_CPU_O,
  output logic [1:0] OUT_PORT_O,
  output logic [1:0] OUT_KIND_O,
  output logic [DATA_W-1:0] OUT_DATA_O,
  input wire logic OUT_READY_I,
  // per-port gates
  output logic [NPORT-1:0] FWD_EN_O,
  output logic [NPORT-1:0] LEARN_EN_O,
  output logic [NPORT-1:0] CPU_RX_EN_O,
  output logic [NPORT-1:0] CPU_TX_EN_O,
  output logic [NPORT*3-1:0] PORT_STATE_O,
  // learning event
  output logic LEARN_O,
  output logic [1:0] LEARN_PORT_O,
  // bridge status
  output logic IS_ROOT_O,
  output logic [ID_W-1:0] ROOT_ID_O,
  output logic HELLO_TX_O,
  output logic [1:0] PREF_PORT_O,
  output logic RANGE_ERR_O,
  output logic CFG_ERR_O
);
  typedef struct packed {
    logic [31:0] div;
    logic tick;
    logic [15:0] prio;
    logic [3:0] hello;
    logic [5:0] age;
    logic [4:0] fwd;
    logic [NPORT-1:0][7:0] pprio;
    logic [NPORT-1:0][15:0] cost;
    logic range_err;
    logic cfg_err;
    logic is_root;
    logic [ID_W-1:0] root_id;
    logic [5:0] age_cnt;
    logic [3:0] hello_cnt;
    logic hello_tx;
    stp_pst_e [NPORT-1:0] pst;
    logic [NPORT-1:0][4:0] fd_cnt;
    logic [NPORT-1:0] fwd_en;
    logic [NPORT-1:0] learn_en;
    logic [NPORT-1:0] cpu_rx_en;
    logic [NPORT-1:0] cpu_tx_en;
    logic learn;
    logic [1:0] learn_port;
    logic [1:0] pref;
  } stp_top_s;

  stp_top_s s_reg;
  stp_top_s s_next;
  stp_stream_if bus ();

  logic [ID_W-1:0] own_id;
  logic [ID_W-1:0] cur_root;
  logic cfg_ok;
  logic take;
  logic pass;
  logic to_cpu;
  stp_pst_e in_st;
  stp_kind_e in_kind;

  // our identifier and the root we currently follow
  assign own_id = {s_reg.prio, STATION_ADDR_I};
  assign cur_root = s_reg.is_root ? own_id : s_reg.root_id;

  // ranges checked on load; priority needs no check
  always_comb begin
    cfg_ok = (HELLO_TIME_I >= HELLO_MIN) &&
             (HELLO_TIME_I <= HELLO_MAX);
    cfg_ok = cfg_ok && (MAX_AGE_I >= AGE_MIN) &&
             (MAX_AGE_I <= AGE_MAX);
    cfg_ok = cfg_ok && (FWD_DELAY_I >= FWD_MIN) &&
             (FWD_DELAY_I <= FWD_MAX);
    for (int p = 0; p < NPORT; p++) begin
      cfg_ok = cfg_ok &&
               (PORT_COST_I[p*16 +: 16] >= COST_MIN);
    end
  end

  // classify an arriving frame by its port state
  assign in_st = s_reg.pst[IN_PORT_I];
  assign in_kind = stp_kind_e'(IN_KIND_I);
  assign take = IN_VALID_I & bus.push_ready;
  always_comb begin
    pass = 1'b0;
    to_cpu = 1'b1;
    case (in_kind)
      K_DATA: begin
        pass = in_st == PS_FWD;
        to_cpu = 1'b0;
      end
      K_BPDU: begin
        pass = in_st != PS_DIS;
      end
      K_MGMT: begin
        pass = 1'b1;
      end
      default: begin
        pass = 1'b0;
      end
    endcase
  end

  // push passing frames; dropped ones are simply consumed
  assign bus.push_valid = IN_VALID_I & pass;
  assign bus.push_word = '{to_cpu: to_cpu, port: IN_PORT_I,
                           kind: in_kind, data: IN_DATA_I};
  assign bus.pop_ready = OUT_READY_I;

  // next state of the whole block
  always_comb begin
    logic fd_exp;
    logic [31:0] best;
    logic [31:0] key;
    fd_exp = 1'b0;
    best = '1;
    key = '0;
    s_next = s_reg;
    s_next.hello_tx = 1'b0;
    s_next.learn = 1'b0;

    // one-second base
    s_next.tick = 1'b0;
    if (s_reg.div >= SEC_CYCLES - 1) begin
      s_next.div = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div = s_reg.div + 32'h1;
    end

    // configuration load, rejected whole when out of range
    if (CFG_LOAD_I) begin
      s_next.range_err = !cfg_ok;
      if (cfg_ok) begin
        s_next.prio = BRIDGE_PRIO_I;
        s_next.hello = HELLO_TIME_I;
        s_next.age = MAX_AGE_I;
        s_next.fwd = FWD_DELAY_I;
        for (int p = 0; p < NPORT; p++) begin
          s_next.pprio[p] = PORT_PRIO_I[p*8 +: 8];
          s_next.cost[p] = PORT_COST_I[p*16 +: 16];
        end
      end
    end
    s_next.cfg_err = {2'h0, s_next.hello} > s_next.age;

    // root election against received root identifiers
    if (RX_BPDU_I) begin
      if (RX_ROOT_ID_I < cur_root) begin
        s_next.is_root = 1'b0;
        s_next.root_id = RX_ROOT_ID_I;
        s_next.age_cnt = s_reg.age;
      end else if (RX_ROOT_ID_I == cur_root && !s_reg.is_root) begin
        s_next.age_cnt = s_reg.age;
      end
    end else if (!s_reg.is_root && own_id < s_reg.root_id) begin
      s_next.is_root = 1'b1;
    end

    // maximum age: silence from the root starts a bid
    if (s_reg.tick && !s_reg.is_root && !RX_BPDU_I) begin
      if (s_reg.age_cnt <= 6'h1) begin
        s_next.is_root = 1'b1;
        s_next.hello_tx = 1'b1;
        s_next.hello_cnt = s_reg.hello;
      end else begin
        s_next.age_cnt = s_reg.age_cnt - 6'h1;
      end
    end

    // hello interval while root, from the stored value
    if (s_reg.tick && s_reg.is_root) begin
      if (s_reg.hello_cnt <= 4'h1) begin
        s_next.hello_tx = 1'b1;
        s_next.hello_cnt = s_reg.hello;
      end else begin
        s_next.hello_cnt = s_reg.hello_cnt - 4'h1;
      end
    end
    if (s_next.is_root) begin
      s_next.root_id = own_id;
    end

    // per-port state sequencing
    for (int p = 0; p < NPORT; p++) begin
      fd_exp = 1'b0;
      if (s_reg.tick && s_reg.pst[p] != PS_FWD &&
          s_reg.pst[p] != PS_DIS) begin
        if (s_reg.fd_cnt[p] <= 5'h1) begin
          fd_exp = 1'b1;
          s_next.fd_cnt[p] = s_reg.fwd;
        end else begin
          s_next.fd_cnt[p] = s_reg.fd_cnt[p] - 5'h1;
        end
      end
      if (!PORT_EN_I[p]) begin
        s_next.pst[p] = PS_DIS;
      end else begin
        case (s_reg.pst[p])
          PS_BLOCK: begin
            if (fd_exp && !PORT_BLOCK_I[p]) begin
              s_next.pst[p] = PS_LISTEN;
            end
          end
          PS_LISTEN: begin
            if (PORT_BLOCK_I[p]) begin
              s_next.pst[p] = PS_BLOCK;
              s_next.fd_cnt[p] = s_reg.fwd;
            end else if (fd_exp) begin
              s_next.pst[p] = PS_LEARN;
            end
          end
          PS_LEARN: begin
            if (fd_exp) begin
              s_next.pst[p] = PS_FWD;
            end
          end
          PS_FWD: begin
            s_next.pst[p] = PS_FWD;
          end
          PS_DIS: begin
            s_next.pst[p] = PS_BLOCK;
            s_next.fd_cnt[p] = s_reg.fwd;
          end
          default: begin
            s_next.pst[p] = PS_BLOCK;
          end
        endcase
      end

      // gates follow the new state
      s_next.fwd_en[p] = s_next.pst[p] == PS_FWD;
      s_next.learn_en[p] = s_next.pst[p] == PS_LEARN ||
                           s_next.pst[p] == PS_FWD;
      s_next.cpu_rx_en[p] = s_next.pst[p] != PS_DIS;
      s_next.cpu_tx_en[p] = s_next.pst[p] != PS_DIS &&
                            s_next.pst[p] != PS_BLOCK;

      // preferred port: lowest cost, then priority, then number
      key = {s_reg.cost[p], s_reg.pprio[p], 6'h0, 2'(p)};
      if (PORT_EN_I[p] && key < best) begin
        best = key;
        s_next.pref = 2'(p);
      end
    end

    // learning event for data taken on a learning port
    if (take && in_kind == K_DATA && s_reg.learn_en[IN_PORT_I]) begin
      s_next.learn = 1'b1;
      s_next.learn_port = IN_PORT_I;
    end
  end

  // state register; reset puts ports blocking and bridge as root
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.prio <= PRIO_RST;
      s_reg.hello <= HELLO_RST;
      s_reg.age <= AGE_RST;
      s_reg.fwd <= FWD_RST;
      s_reg.pprio <= {NPORT{PPRIO_RST}};
      s_reg.cost <= {NPORT{COST_RST}};
      s_reg.is_root <= 1'b1;
      s_reg.root_id <= '1;
      s_reg.age_cnt <= AGE_RST;
      s_reg.hello_cnt <= HELLO_RST;
      s_reg.pst <= {NPORT{PS_BLOCK}};
      s_reg.fd_cnt <= {NPORT{FWD_RST}};
      s_reg.cpu_rx_en <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  // two-entry buffer toward fabric and cpu
  stp_buf2 u_buf (
    .clk_i (CLK_SYS_I),
    .rst_i (RST_I),
    .bus (bus.store)
  );

  // outputs
  assign IN_READY_O = bus.push_ready;
  assign OUT_VALID_O = bus.pop_valid;
  assign OUT_TO_CPU_O = bus.pop_word.to_cpu;
  assign OUT_PORT_O = bus.pop_word.port;
  assign OUT_KIND_O = bus.pop_word.kind;
  assign OUT_DATA_O = bus.pop_word.data;
  assign FWD_EN_O = s_reg.fwd_en;
  assign LEARN_EN_O = s_reg.learn_en;
  assign CPU_RX_EN_O = s_reg.cpu_rx_en;
  assign CPU_TX_EN_O = s_reg.cpu_tx_en;
  assign PORT_STATE_O = s_reg.pst;
  assign LEARN_O = s_reg.learn;
  assign LEARN_PORT_O = s_reg.learn_port;
  assign IS_ROOT_O = s_reg.is_root;
  assign ROOT_ID_O = s_reg.root_id;
  assign HELLO_TX_O = s_reg.hello_tx;
  assign PREF_PORT_O = s_reg.pref;
  assign RANGE_ERR_O = s_reg.range_err;
  assign CFG_ERR_O = s_reg.cfg_err;
endmodule
`default_nettype wire

// >>> verilog/stp_stream_if.sv
// Purpose: carries the word stream between gate and buffer
// Assumes: one clock
// Notes: store side is the buffer, user side the gating logic
`timescale 1ns/1ps
`default_nettype none
interface stp_stream_if;
  import stp_pkg::*;
  logic push_valid;
  logic push_ready;
  stp_word_s push_word;
  logic pop_valid;
  logic pop_ready;
  stp_word_s pop_word;
  modport store (input push_valid, push_word, pop_ready,
                 output push_ready, pop_valid, pop_word);
  modport user (output push_valid, push_word, pop_ready,
                input push_ready, pop_valid, pop_word);
endinterface
`default_nettype wire
